// [bench/pm_block_protect_bench.sv]
// Self-checking bench for the program memory block protection logic
`timescale 1ns/10ps
`default_nettype none
module pm_block_protect_bench;
   import pm_protect_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic        mclk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   mem_size_e   mem_size_in = MEM_32K;
   paddr_t      reg_addr_in = '0;
   logic [7:0]  reg_wdata_in = 8'h00;
   logic        reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0;
   logic [7:0]  reg_rdata_out;
   paddr_t      acc_addr_in = '0;
   paddr_t      pc_addr_in = '0;
   logic        acc_rd_in = 1'b0;
   logic        acc_wr_in = 1'b0;
   logic        acc_tbl_in = 1'b0;
   logic [15:0] mem_rdata_in = 16'h0000;
   logic [15:0] acc_rdata_out;
   logic        acc_allow_out;
   logic        acc_unimpl_out;
   logic [2:0]  acc_region_out;
   logic        rd_prot;
   logic        wr_prot;
   int          n_fail = 0;
   int          check_count = 0;
   localparam logic [2:0] RD = 3'b100;
   localparam logic [2:0] WR = 3'b010;
   localparam logic [2:0] TB = 3'b101;

   always #2 mclk_in = ~mclk_in;

   pm_block_protect pm_block_protect_inst (
      .mclk_in                       (mclk_in),
      .sys_rst_in                    (sys_rst_in),
      .mem_size_in                   (mem_size_in),
      .reg_addr_in                   (reg_addr_in),
      .reg_wdata_in                  (reg_wdata_in),
      .reg_wr_in                     (reg_wr_in),
      .reg_rd_in                     (reg_rd_in),
      .reg_rdata_out                 (reg_rdata_out),
      .acc_addr_in                   (acc_addr_in),
      .pc_addr_in                    (pc_addr_in),
      .acc_rd_in                     (acc_rd_in),
      .acc_wr_in                     (acc_wr_in),
      .acc_tbl_in                    (acc_tbl_in),
      .mem_rdata_in                  (mem_rdata_in),
      .acc_rdata_out                 (acc_rdata_out),
      .acc_allow_out                 (acc_allow_out),
      .acc_unimpl_out                (acc_unimpl_out),
      .acc_region_out                (acc_region_out),
      .data_eeprom_read_protect_out  (rd_prot),
      .data_eeprom_write_protect_out (wr_prot)
   );

   // ----------------------------------------------------------------
   // Compare, bus and access tasks
   // ----------------------------------------------------------------
   task automatic report(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      report({8'h00, got}, {8'h00, exp});
   endtask
   task automatic chk_acc(input logic [4:0] got, input logic [4:0] exp);
      report({11'h000, got}, {11'h000, exp});
   endtask
   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
      report(got, exp);
   endtask
   function automatic logic [4:0] st(input logic al, input region_e r);
      return {al, r == REG_NONE, 3'(r)};
   endfunction
   function automatic logic [15:0] md(input paddr_t a);
      return a[15:0] ^ 16'h5a5a;
   endfunction
   task automatic reg_wr(input paddr_t a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic reg_rd(input paddr_t a, input logic [7:0] exp);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk_reg(reg_rdata_out, exp);
   endtask
   task automatic acc(input paddr_t a, input paddr_t pc, input logic [2:0] k,
                      input logic [4:0] es, input logic [15:0] ed);
      @(posedge mclk_in);
      acc_addr_in  <= a;
      pc_addr_in   <= pc;
      {acc_rd_in, acc_wr_in, acc_tbl_in} <= k;
      mem_rdata_in <= md(a);
      @(posedge mclk_in);
      {acc_rd_in, acc_wr_in, acc_tbl_in} <= 3'b000;
      #1;
      chk_acc({acc_allow_out, acc_unimpl_out, acc_region_out}, es);
      if (k[2])
         chk_data(acc_rdata_out, ed);
   endtask
   task automatic dec(input mem_size_e s, input paddr_t a, input region_e r);
      @(posedge mclk_in);
      mem_size_in <= s;
      acc(a, 21'h000000, RD, st(r != REG_NONE, r), (r == REG_NONE) ? '0 : md(a));
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      reg_rd(21'h300008, 8'h0f);
      reg_rd(21'h300009, 8'hc0);
      reg_rd(21'h30000a, 8'h0f);
      reg_rd(21'h30000b, 8'he0);
      reg_rd(21'h30000c, 8'h0f);
      reg_rd(21'h30000d, 8'h40);
      reg_wr(21'h300010, 8'hff);
      reg_rd(21'h300010, 8'h00);
      mem_size_in <= MEM_8K;
      reg_rd(21'h300008, 8'h03);
      reg_wr(21'h30000a, 8'h0e);
      reg_rd(21'h30000a, 8'h02);
      mem_size_in <= MEM_32K;
      reg_wr(21'h30000a, 8'h0f);
      reg_rd(21'h30000a, 8'h0f);
      $display("test regs done");
   endtask
   task automatic t_decode;
      dec(MEM_8K, 21'h000000, REG_BOOT);
      dec(MEM_8K, 21'h0001ff, REG_BOOT);
      dec(MEM_8K, 21'h000200, REG_BLK0);
      dec(MEM_8K, 21'h000fff, REG_BLK0);
      dec(MEM_8K, 21'h001000, REG_BLK1);
      dec(MEM_8K, 21'h001fff, REG_BLK1);
      dec(MEM_8K, 21'h002000, REG_NONE);
      dec(MEM_8K, 21'h1fffff, REG_NONE);
      dec(MEM_16K, 21'h0007ff, REG_BOOT);
      dec(MEM_16K, 21'h000800, REG_BLK0);
      dec(MEM_16K, 21'h001fff, REG_BLK0);
      dec(MEM_16K, 21'h002000, REG_BLK1);
      dec(MEM_16K, 21'h003fff, REG_BLK1);
      dec(MEM_16K, 21'h004000, REG_NONE);
      dec(MEM_16K, 21'h006000, REG_NONE);
      dec(MEM_32K, 21'h004000, REG_BLK2);
      dec(MEM_32K, 21'h005fff, REG_BLK2);
      dec(MEM_32K, 21'h006000, REG_BLK3);
      dec(MEM_32K, 21'h007fff, REG_BLK3);
      dec(MEM_32K, 21'h008000, REG_NONE);
      $display("test decode done");
   endtask
   task automatic t_wprot;
      reg_wr(21'h30000a, 8'h0d);
      acc(21'h002000, 21'h0, WR, st(1'b0, REG_BLK1), '0);
      acc(21'h000800, 21'h0, WR, st(1'b1, REG_BLK0), '0);
      acc(21'h008000, 21'h0, WR, st(1'b0, REG_NONE), '0);
      reg_wr(21'h30000b, 8'h80);
      reg_rd(21'h30000b, 8'h80);
      acc(21'h000000, 21'h0, WR, st(1'b0, REG_BOOT), '0);
      chk_acc({4'h0, wr_prot}, 5'h00);
      $display("test write protect done");
   endtask
   task automatic t_tblrd;
      reg_wr(21'h30000c, 8'h0e);
      acc(21'h000800, 21'h0, TB, st(1'b0, REG_BLK0), '0);
      acc(21'h000800, 21'h900, TB, st(1'b1, REG_BLK0), md(21'h800));
      reg_wr(21'h300008, 8'h0e);
      acc(21'h000800, 21'h900, TB, st(1'b0, REG_BLK0), '0);
      acc(21'h000800, 21'h0, RD, st(1'b1, REG_BLK0), md(21'h800));
      reg_wr(21'h30000c, 8'h0f);
      reg_wr(21'h300008, 8'h0f);
      acc(21'h000800, 21'h0, TB, st(1'b1, REG_BLK0), md(21'h800));
      reg_wr(21'h300009, 8'h80);
      reg_wr(21'h30000d, 8'h00);
      acc(21'h000010, 21'h800, TB, st(1'b0, REG_BOOT), '0);
      chk_acc({4'h0, rd_prot}, 5'h00);
      reg_wr(21'h300009, 8'h40);
      @(posedge mclk_in);
      #1;
      chk_acc({4'h0, rd_prot}, 5'h01);
      $display("test table read done");
   endtask
   task automatic t_cfg_lock;
      reg_wr(21'h30000e, 8'h01);
      reg_rd(21'h30000e, 8'h01);
      reg_wr(21'h30000b, 8'he0);
      reg_rd(21'h30000b, 8'hc0);
      reg_wr(21'h30000b, 8'h40);
      reg_rd(21'h30000b, 8'h40);
      chk_acc({4'h0, wr_prot}, 5'h01);
      $display("test config lock done");
   endtask

   // ----------------------------------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      // Long enough for every scenario several times over
      #20000;
      n_fail++;
      tally_and_finish();
   end

   initial
   begin
      repeat (10) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      #1;
      chk_acc({acc_allow_out, acc_unimpl_out, acc_region_out}, 5'h00);
      chk_reg(reg_rdata_out, 8'h00);
      t_regs();
      t_decode();
      t_wprot();
      t_tblrd();
      t_cfg_lock();
      tally_and_finish();
   end
endmodule
`default_nettype wire

// [hw/pm_block_decode.sv]
// Program address to protection region decoder
`timescale 1ns/10ps
`default_nettype none
`include "pm_protect_regs.svh"
module pm_block_decode
   import pm_protect_pkg::*;
(
   input  wire pm_protect_pkg::mem_size_e mem_size_in,
   input  wire pm_protect_pkg::paddr_t    addr_in,
   output var  pm_protect_pkg::region_e   region_out
);
   always_comb
   begin
      region_out = REG_NONE;
      case (mem_size_in)
         MEM_8K:
         begin
            if (addr_in <= `BOOT_TOP_SMALL)
               region_out = REG_BOOT;
            else if (addr_in <= `BLK0_TOP_8K)
               region_out = REG_BLK0;
            else if (addr_in <= `MEM_TOP_8K)
               region_out = REG_BLK1;
         end
         MEM_16K, MEM_32K:
         begin
            if (addr_in <= `BOOT_TOP_LARGE)
               region_out = REG_BOOT;
            else if (addr_in <= `BLK0_TOP_LARGE)
               region_out = REG_BLK0;
            else if (addr_in <= `BLK1_TOP_LARGE)
               region_out = REG_BLK1;
            else if (mem_size_in == MEM_32K && addr_in <= `BLK2_TOP_32K)
               region_out = REG_BLK2;
            else if (mem_size_in == MEM_32K && addr_in <= `MEM_TOP_32K)
               region_out = REG_BLK3;
         end
         default:
            region_out = REG_NONE;
      endcase
   end
endmodule
`default_nettype wire

// [hw/pm_block_protect.sv]
// Program memory block protection: config bytes, decode and gating
`timescale 1ns/10ps
`default_nettype none
`include "pm_protect_regs.svh"
//
// Function
// - Program memory splits into three or five protection blocks by size.
// - The boot block is 0.5K bytes on small memory and 2K bytes otherwise.
// - Each block has a read-protect, write-protect and table-read bit.
// - An 8-Kbyte memory maps boot, block 0 and block 1 to fixed ranges.
// - 16 and 32-Kbyte memories map wider ranges; 32K adds blocks 2 and 3.
// - Read, write and table-read bits sit in bytes from 300008h upward.
// - The config write-protect bit is read-only in user mode.
module pm_block_protect
   import pm_protect_pkg::*;
(
   input  wire logic                     mclk_in,
   input  wire logic                     sys_rst_in,
   input  wire pm_protect_pkg::mem_size_e mem_size_in,
   input  wire pm_protect_pkg::paddr_t   reg_addr_in,
   input  wire logic [7:0]               reg_wdata_in,
   input  wire logic                     reg_wr_in,
   input  wire logic                     reg_rd_in,
   output logic [7:0]                    reg_rdata_out,
   input  wire pm_protect_pkg::paddr_t   acc_addr_in,
   input  wire pm_protect_pkg::paddr_t   pc_addr_in,
   input  wire logic                     acc_rd_in,
   input  wire logic                     acc_wr_in,
   input  wire logic                     acc_tbl_in,
   input  wire logic [15:0]              mem_rdata_in,
   output logic [15:0]                   acc_rdata_out,
   output logic                          acc_allow_out,
   output logic                          acc_unimpl_out,
   output logic [2:0]                    acc_region_out,
   output logic                          data_eeprom_read_protect_out,
   output logic                          data_eeprom_write_protect_out
);
   import pm_protect_pkg::*;

   // ---------------------------------------------------------------
   // Configuration bytes
   // ---------------------------------------------------------------
   logic [3:0] block_read_protect_q;
   logic [3:0] block_write_protect_q;
   logic [3:0] block_external_table_read_q;
   logic       boot_read_protect_q;
   logic       boot_write_protect_q;
   logic       boot_external_table_read_q;
   logic       data_eeprom_read_protect_q;
   logic       data_eeprom_write_protect_q;
   logic       config_write_protect_q;
   logic       user_mode_q;
   logic [3:0] blk_mask;

   // Blocks 2 and 3 exist only on the largest memory
   assign blk_mask = (mem_size_in == MEM_32K) ? 4'hf : 4'h3;

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         block_read_protect_q        <= 4'hf;
         block_write_protect_q       <= 4'hf;
         block_external_table_read_q <= 4'hf;
      end
      else if (reg_wr_in)
      begin
         case (reg_addr_in)
            `ADDR_READ_PROT_LOW:
               block_read_protect_q <= reg_wdata_in[3:0] & blk_mask;
            `ADDR_WRITE_PROT_LOW:
               block_write_protect_q <= reg_wdata_in[3:0] & blk_mask;
            `ADDR_TBL_READ_PROT_LOW:
               block_external_table_read_q <= reg_wdata_in[3:0] & blk_mask;
            default:
               block_read_protect_q <= block_read_protect_q;
         endcase
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         boot_read_protect_q         <= 1'b1;
         data_eeprom_read_protect_q  <= 1'b1;
         boot_write_protect_q        <= 1'b1;
         data_eeprom_write_protect_q <= 1'b1;
         boot_external_table_read_q  <= 1'b1;
      end
      else if (reg_wr_in)
      begin
         case (reg_addr_in)
            `ADDR_BOOT_DATA_READ:
            begin
               data_eeprom_read_protect_q <= reg_wdata_in[`BIT_DATA_RD_PROT];
               boot_read_protect_q        <= reg_wdata_in[`BIT_BOOT_RD_PROT];
            end
            `ADDR_BOOT_DATA_CFG_WR:
            begin
               data_eeprom_write_protect_q <= reg_wdata_in[`BIT_DATA_WR_PROT];
               boot_write_protect_q        <= reg_wdata_in[`BIT_BOOT_WR_PROT];
            end
            `ADDR_BOOT_TBL_READ:
               boot_external_table_read_q <= reg_wdata_in[`BIT_BOOT_TBL_READ];
            default:
               boot_read_protect_q <= boot_read_protect_q;
         endcase
      end
   end

   // User mode is entered by software and left only by reset, so code
   // cannot unlock the config write-protect bit once it runs as user
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         user_mode_q <= 1'b0;
      else if (reg_wr_in && reg_addr_in == `ADDR_USER_MODE && reg_wdata_in[0])
         user_mode_q <= 1'b1;
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         config_write_protect_q <= 1'b1;
      else if (reg_wr_in && reg_addr_in == `ADDR_BOOT_DATA_CFG_WR
               && !user_mode_q)
         config_write_protect_q <= reg_wdata_in[`BIT_CFG_WR_PROT];
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
      begin
         case (reg_addr_in)
            `ADDR_READ_PROT_LOW:
               // Reset leaves blocks 2 and 3 set; hide them on 8K and 16K memory
               reg_rdata_out <= {4'h0, block_read_protect_q & blk_mask};
            `ADDR_BOOT_DATA_READ:
               reg_rdata_out <= {data_eeprom_read_protect_q,
                                 boot_read_protect_q, 6'h00};
            `ADDR_WRITE_PROT_LOW:
               reg_rdata_out <= {4'h0, block_write_protect_q & blk_mask};
            `ADDR_BOOT_DATA_CFG_WR:
               reg_rdata_out <= {data_eeprom_write_protect_q,
                                 boot_write_protect_q,
                                 config_write_protect_q, 5'h00};
            `ADDR_TBL_READ_PROT_LOW:
               reg_rdata_out <= {4'h0, block_external_table_read_q & blk_mask};
            `ADDR_BOOT_TBL_READ:
               reg_rdata_out <= {1'b0, boot_external_table_read_q, 6'h00};
            `ADDR_USER_MODE:
               reg_rdata_out <= {7'h00, user_mode_q};
            default:
               reg_rdata_out <= 8'h00;
         endcase
      end
      else
         reg_rdata_out <= 8'h00;
   end

   // ---------------------------------------------------------------
   // Decode and access gating
   // ---------------------------------------------------------------
   region_e acc_region;
   region_e pc_region;

   pm_block_decode u_acc_decode
   (
      .mem_size_in (mem_size_in),
      .addr_in     (acc_addr_in),
      .region_out  (acc_region)
   );

   pm_block_decode u_pc_decode
   (
      .mem_size_in (mem_size_in),
      .addr_in     (pc_addr_in),
      .region_out  (pc_region)
   );

   // Selects one of the three control bits of a region; bit value 0
   // means the protection is active. Used for read, write and table.
   function automatic logic region_bit(input region_e r,
                                       input logic boot_b,
                                       input logic [3:0] blk_b);
      begin
         case (r)
            REG_BOOT: region_bit = boot_b;
            REG_BLK0: region_bit = blk_b[0];
            REG_BLK1: region_bit = blk_b[1];
            REG_BLK2: region_bit = blk_b[2];
            REG_BLK3: region_bit = blk_b[3];
            default:  region_bit = 1'b1;
         endcase
      end
   endfunction

   logic rd_ok;
   logic wr_ok;
   logic tbl_ok;
   logic unimpl;

   assign unimpl = (acc_region == REG_NONE);
   assign rd_ok  = region_bit(acc_region, boot_read_protect_q,
                              block_read_protect_q);
   assign wr_ok  = region_bit(acc_region, boot_write_protect_q,
                              block_write_protect_q);
   // A table read from inside its own block skips the table-read bit, but the read-protect bit still applies
   assign tbl_ok = (pc_region == acc_region) ||
                   region_bit(acc_region, boot_external_table_read_q,
                              block_external_table_read_q);

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         acc_allow_out  <= 1'b0;
         acc_unimpl_out <= 1'b0;
         acc_region_out <= 3'h0;
      end
      else
      begin
         acc_unimpl_out <= unimpl && (acc_rd_in || acc_wr_in);
         acc_region_out <= acc_region;
         if (acc_wr_in)
            acc_allow_out <= !unimpl && wr_ok;
         else if (acc_rd_in && acc_tbl_in)
            acc_allow_out <= !unimpl && rd_ok && tbl_ok;
         else if (acc_rd_in)
            acc_allow_out <= !unimpl;
         else
            acc_allow_out <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         acc_rdata_out <= 16'h0000;
      else if (acc_rd_in && !unimpl &&
               (!acc_tbl_in || (rd_ok && tbl_ok)))
         acc_rdata_out <= mem_rdata_in;
      else
         acc_rdata_out <= 16'h0000;
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         data_eeprom_read_protect_out  <= 1'b0;
         data_eeprom_write_protect_out <= 1'b0;
      end
      else
      begin
         data_eeprom_read_protect_out  <= !data_eeprom_read_protect_q;
         data_eeprom_write_protect_out <= !data_eeprom_write_protect_q;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence cfg_wr_locked;
      reg_wr_in && reg_addr_in == `ADDR_BOOT_DATA_CFG_WR && user_mode_q;
   endsequence

   chk_cfg_wr_lock: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      cfg_wr_locked |=> $stable(config_write_protect_q))
      else $error("config write-protect changed in user mode");

   chk_unimpl_zero: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (acc_rd_in && unimpl) |=> (acc_rdata_out == 16'h0000))
      else $error("unimplemented read returned nonzero");

   chk_boot_small: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (mem_size_in == MEM_8K && acc_addr_in == 21'h000200)
      |-> acc_region == REG_BLK0)
      else $error("small boot block too large");

   chk_boot_large: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (mem_size_in != MEM_8K && acc_addr_in == 21'h0007ff)
      |-> acc_region == REG_BOOT)
      else $error("large boot block too small");

   chk_blk3_32k: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (mem_size_in == MEM_16K && acc_addr_in == 21'h006000)
      |-> acc_region == REG_NONE)
      else $error("block 3 decoded on 16K memory");

   chk_8k_top: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (mem_size_in == MEM_8K && acc_addr_in == 21'h001fff)
      |-> acc_region == REG_BLK1)
      else $error("8K top not in block 1");

   chk_wr_gate: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (acc_wr_in && !wr_ok) |=> !acc_allow_out)
      else $error("write allowed to protected block");

   chk_rd_back: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      (reg_wr_in && reg_addr_in == `ADDR_WRITE_PROT_LOW) ##1 !reg_wr_in ##1
      (reg_rd_in && reg_addr_in == `ADDR_WRITE_PROT_LOW && !reg_wr_in)
      |=> reg_rdata_out[3:0] == ($past(reg_wdata_in, 3) & $past(blk_mask, 3)))
      else $error("write-protect byte did not read back");
endmodule
`default_nettype wire

// [inc/pm_protect_pkg.sv]
// Types shared by the protection block files
package pm_protect_pkg;
   typedef enum logic [1:0] {MEM_8K, MEM_16K, MEM_32K} mem_size_e;
   typedef enum logic [2:0] {
      REG_BOOT, REG_BLK0, REG_BLK1, REG_BLK2, REG_BLK3, REG_NONE
   } region_e;
   typedef logic [20:0] paddr_t;
endpackage

// [inc/pm_protect_regs.svh]
// Offsets, field positions, reset values and memory sizes of block protection
`ifndef PM_PROTECT_REGS_SVH
`define PM_PROTECT_REGS_SVH

`define ADDR_READ_PROT_LOW      21'h300008
`define ADDR_BOOT_DATA_READ     21'h300009
`define ADDR_WRITE_PROT_LOW     21'h30000a
`define ADDR_BOOT_DATA_CFG_WR   21'h30000b
`define ADDR_TBL_READ_PROT_LOW  21'h30000c
`define ADDR_BOOT_TBL_READ      21'h30000d
`define ADDR_USER_MODE          21'h30000e

`define BIT_DATA_RD_PROT        7
`define BIT_BOOT_RD_PROT        6
`define BIT_DATA_WR_PROT        7
`define BIT_BOOT_WR_PROT        6
`define BIT_CFG_WR_PROT         5
`define BIT_BOOT_TBL_READ       6

`define RST_LOW_BYTE            8'h0f
`define RST_HIGH_BYTE           8'hc0
`define RST_CFG_WR_BYTE         8'he0
`define RST_BOOT_TBL_BYTE       8'h40

`define BOOT_TOP_SMALL          21'h0001ff
`define BOOT_TOP_LARGE          21'h0007ff
`define MEM_TOP_8K              21'h001fff
`define MEM_TOP_16K             21'h003fff
`define MEM_TOP_32K             21'h007fff
`define BLK0_TOP_8K             21'h000fff
`define BLK0_TOP_LARGE          21'h001fff
`define BLK1_TOP_LARGE          21'h003fff
`define BLK2_TOP_32K            21'h005fff

`endif
